// ### ebc_consts.svh
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH
// Timing config word layout per region
`define CFG_AB_POS      0
`define CFG_AB_W        1
`define CFG_EXT_POS     1
`define CFG_EXT_W       2
`define CFG_C_POS       3
`define CFG_C_W         2
`define CFG_D_POS       5
`define CFG_E_POS       6
`define CFG_E_W         5
`define CFG_F_POS       11
`define CFG_F_W         2
`define CFG_RDY_POS     13
`define CFG_WIDTH       14
// Bus clock period in system clocks
`define BUS_CLK_DIV     2
`endif

// ### ebc_pkg.sv
package ebc_pkg;
   typedef enum logic [2:0]
   {
      PH_IDLE,
      PH_AB,
      PH_C,
      PH_D,
      PH_E,
      PH_F
   } phase_t;
endpackage

// ### ebc_fifo.sv
module ebc_fifo
   import ebc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk_sys_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("ebc_fifo depth must be a power of two >= 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              full;
   wire              empty;
   wire              push;
   wire              pop;
   assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                  (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign push  = in_valid_in && !full;
   assign pop   = out_ready_in && !empty;
   assign in_ready_out  = !full;
   assign out_valid_out = !empty;
   assign out_data_out  = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clk_sys_in)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data_in;
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

// ### external_bus_cycle_sequencer.sv
`include "ebc_consts.svh"
// Notes on behaviour
// - Each cycle walks address setup, command delay, data setup, access, hold; delay, data setup and hold phases of zero length are skipped.
// - Phase lengths come from a per-region timing configuration word.
// - With handshake on, access ends only once ready is seen.
// - Command delay 0..3 periods; access 1..32 periods.
// - Address setup 1..2 periods, plus 0..3 on region change.
// - Write-data setup or turnaround is 0 or 1 period.
// - Hold after command ends is 0..3 periods.
// - Read data captured on edge ending access, raising read strobe.
// - Address change after strobe end cannot corrupt captured data.
module external_bus_cycle_sequencer
   import ebc_pkg::*;
#(
   parameter int REGIONS    = 4,
   parameter int ADDR_W     = 24,
   parameter int DATA_W     = 16,
   parameter int FIFO_DEPTH = 8
)
(
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_b_in,
   input  wire logic [REGIONS*`CFG_WIDTH-1:0] region_cycle_timing_config_in,
   input  wire logic                          req_valid_in,
   output logic                               req_ready_out,
   input  wire logic                          req_write_in,
   input  wire logic [$clog2(REGIONS)-1:0]    req_region_in,
   input  wire logic [ADDR_W-1:0]             req_addr_in,
   input  wire logic [DATA_W-1:0]             req_wdata_in,
   input  wire logic                          req_upper_in,
   output logic                               rdata_valid_out,
   output logic      [DATA_W-1:0]             rdata_out,
   output logic                               busy_out,
   output logic      [ADDR_W-1:0]             addr_out,
   output logic      [REGIONS-1:0]            cs_b_out,
   output logic                               rd_b_out,
   output logic                               wr_b_out,
   output logic                               upper_byte_enable_b_out,
   output logic      [DATA_W-1:0]             data_out,
   output logic                               data_oe_out,
   input  wire logic [DATA_W-1:0]             data_in,
   input  wire logic                          ready_b_in
);
   localparam int RW = $clog2(REGIONS);
   localparam int QW = 1 + RW + ADDR_W + DATA_W + 1;
   initial
   begin
      if (REGIONS < 2 || `BUS_CLK_DIV < 1)
         $error("sequencer needs two regions and a divider of one or more");
   end

   // Request queue from the on-chip bus
   wire          q_valid;
   wire          q_pop;
   wire [QW-1:0] q_data;
   ebc_fifo #(.WIDTH(QW), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_sys_in    (clk_sys_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (req_valid_in && req_ready_out),
      .in_ready_out  (),
      .in_data_in    ({req_write_in, req_region_in, req_addr_in,
                       req_wdata_in, req_upper_in}),
      .out_valid_out (q_valid),
      .out_ready_in  (q_pop),
      .out_data_out  (q_data)
   );
   // Ready drops once a registered count of queued entries reaches FIFO_DEPTH - 1, one short of full, keeping outputs flopped
   logic [$clog2(FIFO_DEPTH):0] q_count;

   function automatic logic [`CFG_WIDTH-1:0] cfg_of(input logic [RW-1:0] r);
      cfg_of = region_cycle_timing_config_in[r*`CFG_WIDTH +: `CFG_WIDTH];
   endfunction

   phase_t           phase;
   phase_t           next_phase;
   logic [5:0]       per_cnt;
   logic [1:0]       tick_cnt;
   logic [RW-1:0]    cur_region;
   logic             last_valid;
   logic             cur_write;
   logic [`CFG_WIDTH-1:0] cfg;

   wire              tick;
   wire [RW-1:0]     q_region;
   wire [`CFG_WIDTH-1:0] q_cfg;
   wire              q_write;
   wire              region_change;
   wire [5:0]        ab_len;
   wire [5:0]        c_len;
   wire              d_len;
   wire [5:0]        e_len;
   wire [5:0]        f_len;
   wire              rdy_en;
   wire              phase_done;
   wire              access_end;
   wire              start;

   assign tick     = (tick_cnt == 2'(`BUS_CLK_DIV - 1));
   assign q_write  = q_data[QW-1];
   assign q_region = q_data[QW-2 -: RW];
   assign q_cfg    = cfg_of(q_region);
   assign region_change = !last_valid || (q_region != cur_region);
   // Setup length fixed at request start
   assign ab_len = 6'(q_cfg[`CFG_AB_POS]) + 6'd1 +
                   (region_change ? 6'(q_cfg[`CFG_EXT_POS +: `CFG_EXT_W])
                                  : 6'd0);
   assign c_len  = 6'(cfg[`CFG_C_POS +: `CFG_C_W]);
   assign d_len  = cfg[`CFG_D_POS];
   assign e_len  = 6'(cfg[`CFG_E_POS +: `CFG_E_W]) + 6'd1;
   assign f_len  = 6'(cfg[`CFG_F_POS +: `CFG_F_W]);
   assign rdy_en = cfg[`CFG_RDY_POS];
   // Access may only end on the last period, ready sampled then
   assign access_end = (phase == PH_E) && tick && (per_cnt == 6'd1) &&
                       (!rdy_en || !ready_b_in);
   assign phase_done = tick && (per_cnt <= 6'd1);
   assign start = (phase == PH_IDLE) && q_valid;
   assign q_pop = start;

   always_comb
   begin
      next_phase = phase;
      unique case (phase)
         PH_IDLE: if (q_valid) next_phase = PH_AB;
         // Zero-length phases are skipped so they cost no clock at all
         PH_AB:   if (phase_done)
                     next_phase = (c_len != 6'd0) ? PH_C :
                                  d_len ? PH_D : PH_E;
         PH_C:    if (phase_done) next_phase = d_len ? PH_D : PH_E;
         PH_D:    if (phase_done) next_phase = PH_E;
         PH_E:    if (access_end)
                     next_phase = (f_len != 6'd0) ? PH_F : PH_IDLE;
         PH_F:    if (phase_done) next_phase = PH_IDLE;
      endcase
   end

   wire enter = (next_phase != phase);
   wire [5:0] next_len = (next_phase == PH_AB) ? ab_len :
                         (next_phase == PH_C)  ? c_len  :
                         (next_phase == PH_D)  ? 6'(d_len) :
                         (next_phase == PH_E)  ? e_len  : f_len;

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         phase      <= PH_IDLE;
         per_cnt    <= '0;
         tick_cnt   <= '0;
         cur_region <= '0;
         last_valid <= 1'b0;
         cur_write  <= 1'b0;
         cfg        <= '0;
         q_count    <= '0;
      end
      else
      begin
         phase    <= next_phase;
         tick_cnt <= (enter || tick) ? 2'd0 : tick_cnt + 2'd1;
         if (enter)
            per_cnt <= next_len;
         else if (tick && per_cnt > 6'd1)
            per_cnt <= per_cnt - 6'd1;
         // Access holds while ready is inactive
         if (start)
         begin
            cur_region <= q_region;
            last_valid <= 1'b1;
            cur_write  <= q_write;
            cfg        <= q_cfg;
         end
         q_count <= q_count + ((req_valid_in && req_ready_out) ? 1'b1 : 1'b0)
                    - (q_pop ? 1'b1 : 1'b0);
      end
   end

   // Bus pins; all driven from flops
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         addr_out                <= '0;
         cs_b_out                <= '1;
         rd_b_out                <= 1'b1;
         wr_b_out                <= 1'b1;
         upper_byte_enable_b_out <= 1'b1;
         data_out                <= '0;
         data_oe_out             <= 1'b0;
         rdata_out               <= '0;
         rdata_valid_out         <= 1'b0;
         busy_out                <= 1'b0;
         req_ready_out           <= 1'b0;
      end
      else
      begin
         req_ready_out   <= (q_count < FIFO_DEPTH - 1);
         busy_out        <= (next_phase != PH_IDLE);
         rdata_valid_out <= 1'b0;
         if (start)
         begin
            addr_out                <= q_data[DATA_W+1 +: ADDR_W];
            data_out                <= q_data[1 +: DATA_W];
            upper_byte_enable_b_out <= !q_data[0];
            cs_b_out                <= ~(REGIONS'(1) << q_region);
         end
         // Read strobe through D and E, write strobe in E only; data driven from D to end of F
         if (next_phase == PH_D || (next_phase == PH_E && phase != PH_E))
         begin
            rd_b_out    <= cur_write;
            wr_b_out    <= !(cur_write && next_phase == PH_E);
            data_oe_out <= cur_write && (next_phase == PH_D || d_len);
         end
         if (next_phase == PH_E && cur_write)
            data_oe_out <= 1'b1;
         if (access_end)
         begin
            rd_b_out <= 1'b1;
            wr_b_out <= 1'b1;
            // Same edge that raises the strobe; bus data after it unused
            if (!cur_write)
            begin
               rdata_out       <= data_in;
               rdata_valid_out <= 1'b1;
            end
         end
         if (next_phase == PH_IDLE && phase != PH_IDLE)
         begin
            data_oe_out <= 1'b0;
            cs_b_out    <= '1;
         end
      end
   end
endmodule

// ### ebc_assertions.sv
module ebc_checker
#(
   parameter int REGIONS = 4,
   parameter int DATA_W  = 16
)
(
   input wire logic               clk_sys_in,
   input wire logic               rst_b_in,
   input wire logic               busy_out,
   input wire logic [REGIONS-1:0] cs_b_out,
   input wire logic               rd_b_out,
   input wire logic               wr_b_out,
   input wire logic               data_oe_out,
   input wire logic               rdata_valid_out,
   input wire logic [DATA_W-1:0]  rdata_out,
   input wire logic [DATA_W-1:0]  data_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   strobe_excl_a: assert property (rd_b_out || wr_b_out)
      else $error("read and write strobes low together");
   cs_onehot_a: assert property ($onehot0(~cs_b_out))
      else $error("more than one region selected");
   strobe_cs_a: assert property (!(rd_b_out && wr_b_out) |-> !(&cs_b_out))
      else $error("strobe low without a region selected");
   read_cap_a: assert property ($rose(rd_b_out) |-> rdata_out == $past(data_in))
      else $error("read data not taken at strobe end");
   rdv_pulse_a: assert property (rdata_valid_out |=> !rdata_valid_out)
      else $error("read data valid longer than one cycle");
   oe_read_a: assert property (data_oe_out |-> rd_b_out)
      else $error("bus driven during read strobe");
   rd_min_a: assert property ($fell(rd_b_out) |=> !rd_b_out)
      else $error("read strobe shorter than one period");
   wr_min_a: assert property ($fell(wr_b_out) |=> !wr_b_out)
      else $error("write strobe shorter than one period");
   idle_a: assert property (!busy_out |-> rd_b_out && wr_b_out)
      else $error("strobe low while idle");
endmodule

bind external_bus_cycle_sequencer ebc_checker #(.REGIONS(REGIONS), .DATA_W(DATA_W))
   chk (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .busy_out(busy_out),
   .cs_b_out(cs_b_out), .rd_b_out(rd_b_out), .wr_b_out(wr_b_out),
   .data_oe_out(data_oe_out), .rdata_valid_out(rdata_valid_out),
   .rdata_out(rdata_out), .data_in(data_in));

// ### ebc_mem_model.sv
module ebc_mem_model
(
   input  wire logic        clk_sys_in,
   input  wire logic        rd_b_in,
   input  wire logic        wr_b_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic [3:0]  wait_in,
   output logic      [15:0] rdata_out,
   output logic             ready_b_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [16];
   logic [15:0] last = 16'h0000;
   logic [4:0]  cnt  = 5'h00;
   // Released bus shows the inverse, so stale data cannot pass
   assign rdata_out   = !rd_b_in ? mem[addr_in] : ~last;
   assign ready_b_out = !(cnt >= 5'(wait_in));
   always @(posedge clk_sys_in)
   begin
      cnt <= (rd_b_in && wr_b_in) ? 5'h00 : cnt + 5'(cnt != 5'h1f);
      if (!rd_b_in) last <= mem[addr_in];
      if (!wr_b_in) mem[addr_in] <= wdata_in;
   end
endmodule

// ### external_bus_cycle_sequencer_tb_top.sv
`include "ebc_consts.svh"
module external_bus_cycle_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys_in = 0, rst_b_in = 0, req_valid_in = 0;
   logic        req_write_in = 0, req_upper_in = 0;
   logic [55:0] cfg = '0;
   logic [1:0]  req_region_in = '0;
   logic [23:0] req_addr_in = '0;
   logic [15:0] req_wdata_in = '0, rd_bus, wr_bus, got;
   logic [3:0]  cs_b_out, wait_cyc = 4'hf;
   logic        req_ready_out, rdata_valid_out, busy_out, rd_b_out, wr_b_out;
   logic        upper_byte_enable_b_out, data_oe_out, ready_b;
   logic [23:0] addr_out;
   int          err_count = 0, cmp_count = 0, n_cs, n_wr, n_rd, acc, i;
   int          n_oe, ad, ub;
   int          tb [3][5] = '{'{0,0,0,0,0}, '{1,3,1,31,3}, '{0,2,0,5,1}};

   always #2.5 clk_sys_in = ~clk_sys_in;

   external_bus_cycle_sequencer dut (.clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in), .region_cycle_timing_config_in(cfg),
      .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
      .req_write_in(req_write_in), .req_region_in(req_region_in),
      .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
      .req_upper_in(req_upper_in), .rdata_valid_out(rdata_valid_out),
      .rdata_out(got), .busy_out(busy_out), .addr_out(addr_out),
      .cs_b_out(cs_b_out), .rd_b_out(rd_b_out), .wr_b_out(wr_b_out),
      .upper_byte_enable_b_out(upper_byte_enable_b_out), .data_out(wr_bus),
      .data_oe_out(data_oe_out), .data_in(rd_bus), .ready_b_in(ready_b));
   ebc_mem_model mem (.clk_sys_in(clk_sys_in), .rd_b_in(rd_b_out),
      .wr_b_in(wr_b_out), .addr_in(addr_out[3:0]), .wdata_in(wr_bus),
      .wait_in(wait_cyc), .rdata_out(rd_bus), .ready_b_out(ready_b));

   function automatic logic [13:0] cw(int ab, x, c, d, e, f, r);
      return {r[0], f[1:0], e[4:0], d[0], c[1:0], x[1:0], ab[0]};
   endfunction

   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", n, exp, seen);
      end
   endtask

   task automatic access(bit w, int rg, logic [15:0] d);
      bit seen;
      seen = 0; n_cs = 0; n_wr = 0; n_rd = 0; n_oe = 0; ad = -1; ub = -1;
      req_valid_in  <= 1; req_write_in <= w; req_region_in <= 2'(rg);
      req_addr_in   <= 24'(rg * 16 + 5); req_wdata_in <= d;
      req_upper_in  <= w;
      do @(posedge clk_sys_in); while (req_ready_out !== 1'b1);
      req_valid_in <= 0;
      for (int k = 0; k < 600; k++)
      begin
         @(posedge clk_sys_in);
         n_cs += (cs_b_out !== 4'hf);
         n_wr += (wr_b_out === 1'b0);
         n_rd += (rd_b_out === 1'b0);
         n_oe += (data_oe_out === 1'b1);
         if (cs_b_out !== 4'hf)
         begin
            ad = addr_out;
            ub = upper_byte_enable_b_out;
         end
         if (busy_out === 1'b1) seen = 1;
         else if (seen) break;
      end
   endtask

   task automatic t_lengths;
      for (i = 0; i < 3; i++)
      begin
         cfg[13:0] <= cw(tb[i][0], 0, tb[i][1], tb[i][2], tb[i][3], tb[i][4], 0);
         access(1, 0, 16'h5a00 + 16'(i));
         check("cs_len", n_cs, 2 * (tb[i][0] + 2 + tb[i][1] + tb[i][2]
            + tb[i][3] + tb[i][4]));
         check("wr_len", n_wr, 2 * (tb[i][3] + 1));
         check("oe_len", n_oe, 2 * (tb[i][2] + tb[i][3] + 1 + tb[i][4]));
         check("addr", ad, 5);
         check("ube_wr", ub, 0);
         access(0, 0, 16'h0000);
         check("rd_len", n_rd, 2 * (tb[i][2] + tb[i][3] + 1));
         check("oe_rd", n_oe, 0);
         check("ube_rd", ub, 1);
         check("rdata", got, 16'h5a00 + 16'(i));
      end
   endtask

   task automatic t_region;
      cfg[27:14] <= cw(0, 3, 0, 0, 0, 0, 0);
      cfg[41:28] <= cw(0, 2, 0, 0, 0, 0, 0);
      access(1, 1, 16'h1111);
      check("cs_change", n_cs, 10);
      access(1, 1, 16'h2222);
      check("cs_same", n_cs, 4);
      access(1, 2, 16'h3333);
      check("cs_change2", n_cs, 8);
   endtask

   task automatic t_ready;
      cfg[55:42] <= cw(0, 0, 0, 0, 0, 0, 1);
      wait_cyc <= 4'h0;
      access(1, 3, 16'h4444);
      check("wr_ready", n_wr, 2);
      wait_cyc <= 4'h9;
      access(1, 3, 16'h4545);
      check("wr_stall", n_wr >= 10, 1);
      access(0, 3, 16'h0000);
      check("rd_stall", got, 16'h4545);
      wait_cyc <= 4'hf;
   endtask

   task automatic t_fifo;
      acc = 0;
      cfg[13:0] <= cw(1, 0, 3, 1, 31, 3, 0);
      req_valid_in <= 1; req_write_in <= 1; req_region_in <= 2'd0;
      for (i = 0; i < 14; i++)
      begin
         @(posedge clk_sys_in);
         acc += (req_ready_out === 1'b1);
      end
      req_valid_in <= 0;
      check("fifo_full", acc >= 8 && acc < 14, 1);
      // Busy drops for a clock between queued cycles, so wait for a run
      acc = 0;
      for (i = 0; i < 3000 && acc < 4; i++)
      begin
         @(posedge clk_sys_in);
         acc = (busy_out === 1'b0) ? acc + 1 : 0;
      end
      check("drained", acc, 4);
      check("ready_back", req_ready_out, 1);
   endtask

   task automatic end_of_test;
      if (err_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Limit is over thirty times the longest expected run
   initial
   begin
      #200us;
      err_count++;
      end_of_test();
   end

   initial
   begin
      repeat (3) @(posedge clk_sys_in);
      rst_b_in <= 1;
      repeat (2) @(posedge clk_sys_in);
      t_lengths();
      t_region();
      t_ready();
      t_fifo();
      end_of_test();
   end
endmodule
